// ---- logic/asi_baud_gen.sv ----
// Shared baud generator: 32 selectable rates, a receiver sample tick and a bit tick.
// Assumes one clock; the config may change at any time and is compared against the running count at once.
module asi_baud_gen (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire asi_pkg::asi_baud_cfg_t cfg,
  output logic                       rt_tick_q,
  output logic                       bit_tick_q
);

  logic [4:0]  presc;
  logic [11:0] rt_period;
  logic [11:0] rt_cnt_q;
  logic [3:0]  rt_phase_q;

  // Prescaler times a power of two gives 4 x 8 rates
  always_comb begin
    case (cfg.presc_sel)
      2'h0:    presc = asi_pkg::PRESC_1;
      2'h1:    presc = asi_pkg::PRESC_3;
      2'h2:    presc = asi_pkg::PRESC_4;
      default: presc = asi_pkg::PRESC_13;
    endcase
    rt_period = 12'(presc) << cfg.rate_sel;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rt_cnt_q  <= 12'h000;
      rt_tick_q <= 1'b0;
    end else if (rt_cnt_q + 12'h001 >= rt_period) begin
      rt_cnt_q  <= 12'h000;
      rt_tick_q <= 1'b1;
    end else begin
      rt_cnt_q  <= rt_cnt_q + 12'h001;
      rt_tick_q <= 1'b0;
    end
  end

  // Bit tick every sixteenth sample tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rt_phase_q <= 4'h0;
      bit_tick_q <= 1'b0;
    end else begin
      bit_tick_q <= 1'b0;
      if (rt_tick_q) begin
        rt_phase_q <= rt_phase_q + 4'h1;
        bit_tick_q <= (rt_phase_q == asi_pkg::RT_PER_BIT);
      end
    end
  end

endmodule

// ---- logic/asi_pkg.sv ----
// Package for the asynchronous serial transmitter: register map, field layout, timing.
// Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
package asi_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0]  IDX_CTRL1    = 8'h13;
  localparam logic [7:0]  IDX_CTRL2    = 8'h14;
  localparam logic [7:0]  IDX_CTRL3    = 8'h15;
  localparam logic [7:0]  IDX_STAT1    = 8'h16;
  localparam logic [7:0]  IDX_STAT2    = 8'h17;
  localparam logic [7:0]  IDX_DATA     = 8'h18;
  localparam logic [7:0]  IDX_BAUD     = 8'h19;
  localparam logic [7:0]  IDX_IRQ_STS  = 8'h1A;
  localparam logic [7:0]  IDX_IRQ_MSK  = 8'h1B;

  // Control one fields
  localparam int          C1_ENABLE    = 6;
  localparam int          C1_INVERT    = 5;
  localparam int          C1_NINE_BIT  = 4;
  // Control two fields
  localparam int          C2_TXE_IE    = 7;
  localparam int          C2_TC_IE     = 6;
  localparam int          C2_TX_EN     = 3;
  localparam int          C2_BREAK     = 0;
  // Control three field
  localparam int          C3_TX_NINTH  = 6;
  // Status one fields
  localparam int          S1_TXE       = 7;
  localparam int          S1_TC        = 6;
  // Interrupt status and mask fields
  localparam int          IRQ_TXE      = 0;
  localparam int          IRQ_TC       = 1;
  localparam int          IRQ_W        = 2;

  localparam logic [7:0]  RST_REG      = 8'h00;
  localparam logic [7:0]  C3_WMASK     = 8'h40;
  localparam logic [7:0]  BAUD_WMASK   = 8'h37;

  // Frame lengths in bits: start, data, stop
  localparam logic [3:0]  LEN_8BIT     = 4'hA;
  localparam logic [3:0]  LEN_9BIT     = 4'hB;
  localparam logic [3:0]  LEN_MARK     = 4'h1;
  localparam logic [10:0] ALL_ONES     = 11'h7FF;
  localparam logic [10:0] ALL_ZEROS    = 11'h000;

  // Baud generator: prescaler choices and receiver oversampling
  localparam logic [4:0]  PRESC_1      = 5'h01;
  localparam logic [4:0]  PRESC_3      = 5'h03;
  localparam logic [4:0]  PRESC_4      = 5'h04;
  localparam logic [4:0]  PRESC_13     = 5'h0D;
  localparam logic [3:0]  RT_PER_BIT   = 4'hF;

  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0]  HSIZE_WORD    = 3'h2;

  typedef struct packed {
    logic [1:0] presc_sel;
    logic [2:0] rate_sel;
  } asi_baud_cfg_t;

  typedef struct packed {
    logic        write;
    logic [7:0]  index;
    logic        valid;
  } asi_access_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_PRE  = 4'h2,
    ST_SEND = 4'h4,
    ST_BRK  = 4'h8
  } asi_tx_state_t;

endpackage

// ---- logic/asi_tx.sv ----
// Transmit path of an asynchronous serial interface with an AHB-Lite register slave.
// Assumes a single 200 MHz clock, word accesses only, and a receiver fed by rx_rt_tick.
// How it works
// - Transmit runs on its own state but shares the baud generator whose sample tick feeds rx.
// - The baud generator offers 32 rates chosen by software.
// - The line carries mark/space NRZ levels with no clock alongside.
// - Characters carry 8 or 9 data bits chosen by the length bit of control one.
// - In 9-bit mode the ninth bit comes from the ninth-bit field of control three.
// - The data register is a write-only holding buffer in front of the shift register.
// - Enabling the transmitter while the module is on sends an all-ones preamble before the first character.
// - A loaded character gets a 0 start bit at the bottom and a 1 stop bit at the top.
// - The empty flag sets whenever the buffer hands its character to the shift register.
// - The transmit interrupt is raised while the empty flag and its enable are both set.
// - With nothing to send the line rests at 1.
// - Clearing the module enable releases the pin at once.
// - With inversion set every level on the pin is inverted.
// - While send-break is set, all-zero break characters are loaded repeatedly.
// - The complete flag is set only with shifter and buffer empty and no break or preamble.
module asi_tx (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             txd_q,
  output logic             txd_oe_n_q,
  output logic             irq_q,
  output logic             rx_rt_tick
);

  localparam int IRQ_W_L = asi_pkg::IRQ_W;

  asi_pkg::asi_access_t    acc_q;
  asi_pkg::asi_baud_cfg_t  baud_cfg;
  asi_pkg::asi_tx_state_t  state_q;

  logic [7:0]  ctrl1_q;
  logic [7:0]  ctrl2_q;
  logic [7:0]  ctrl3_q;
  logic [7:0]  baud_q;
  logic [7:0]  buf_q;
  logic        buf_full_q;
  logic        txe_q;
  logic        tc_q;
  logic        tc_d;
  logic        pre_pend_q;
  logic [IRQ_W_L-1:0] irq_sts_q;
  logic [IRQ_W_L-1:0] irq_msk_q;
  logic [10:0] shreg_q;
  logic [3:0]  bits_left_q;
  logic        bit_tick;
  logic        take;
  logic        wr_ctrl1;
  logic        wr_ctrl2;
  logic        wr_ctrl3;
  logic        wr_data;
  logic        wr_baud;
  logic        wr_sts;
  logic        wr_msk;
  logic [7:0]  wdata8;
  logic [7:0]  rdata8;
  logic        mod_en;
  logic        tx_en;
  logic        nine;
  logic [3:0]  frame_len;
  logic        frame_end;
  logic        do_load;
  logic        load_char;
  logic        line;
  logic        req;

  // Bus: address phase capture; only aligned word accesses in the lowest 1 KB are taken
  assign req  = hsel && hready && (htrans == asi_pkg::HTRANS_NONSEQ);
  assign take = req && (hsize == asi_pkg::HSIZE_WORD) && (haddr[1:0] == 2'h0)
                && (haddr[31:10] == 22'h0);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_q <= '0;
    end else begin
      acc_q.valid <= take;
      acc_q.write <= hwrite;
      acc_q.index <= haddr[9:2];
    end
  end

  // Zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Data phase write strobes
  assign wdata8   = hwdata[7:0];
  assign wr_ctrl1 = acc_q.valid && acc_q.write && (acc_q.index == asi_pkg::IDX_CTRL1);
  assign wr_ctrl2 = acc_q.valid && acc_q.write && (acc_q.index == asi_pkg::IDX_CTRL2);
  assign wr_ctrl3 = acc_q.valid && acc_q.write && (acc_q.index == asi_pkg::IDX_CTRL3);
  assign wr_data  = acc_q.valid && acc_q.write && (acc_q.index == asi_pkg::IDX_DATA);
  assign wr_baud  = acc_q.valid && acc_q.write && (acc_q.index == asi_pkg::IDX_BAUD);
  assign wr_sts   = acc_q.valid && acc_q.write && (acc_q.index == asi_pkg::IDX_IRQ_STS);
  assign wr_msk   = acc_q.valid && acc_q.write && (acc_q.index == asi_pkg::IDX_IRQ_MSK);

  assign mod_en    = ctrl1_q[asi_pkg::C1_ENABLE];
  assign tx_en     = ctrl2_q[asi_pkg::C2_TX_EN];
  assign nine      = ctrl1_q[asi_pkg::C1_NINE_BIT];
  assign frame_len = nine ? asi_pkg::LEN_9BIT : asi_pkg::LEN_8BIT;

  // Read mux; the data buffer is write-only and reads as zero
  always_comb begin
    case (haddr[9:2])
      asi_pkg::IDX_CTRL1:   rdata8 = ctrl1_q;
      asi_pkg::IDX_CTRL2:   rdata8 = ctrl2_q;
      asi_pkg::IDX_CTRL3:   rdata8 = ctrl3_q;
      asi_pkg::IDX_STAT1:   rdata8 = {txe_q, tc_q, 6'h00};
      asi_pkg::IDX_STAT2:   rdata8 = 8'h00;
      asi_pkg::IDX_BAUD:    rdata8 = baud_q;
      asi_pkg::IDX_IRQ_STS: rdata8 = {6'h00, irq_sts_q};
      asi_pkg::IDX_IRQ_MSK: rdata8 = {6'h00, irq_msk_q};
      default:              rdata8 = 8'h00;
    endcase
  end

  // Read data registered at the address phase edge
  // An illegal read still answers OKAY but returns zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (req && !hwrite) begin
      hrdata <= take ? {24'h000000, rdata8} : 32'h0000_0000;
    end
  end

  // Control registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl1_q <= asi_pkg::RST_REG;
      ctrl2_q <= asi_pkg::RST_REG;
      ctrl3_q <= asi_pkg::RST_REG;
      baud_q  <= asi_pkg::RST_REG;
    end else begin
      if (wr_ctrl1) begin
        ctrl1_q <= wdata8;
      end
      if (wr_ctrl2) begin
        ctrl2_q <= wdata8;
      end
      if (wr_ctrl3) begin
        ctrl3_q <= wdata8 & asi_pkg::C3_WMASK;
      end
      if (wr_baud) begin
        baud_q <= wdata8 & asi_pkg::BAUD_WMASK;
      end
    end
  end

  // Enabling the transmitter queues a preamble; toggling it mid-frame queues another
  // Cleared when the preamble is loaded, ahead of any break or character
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_pend_q <= 1'b0;
    end else if (wr_ctrl2 && wdata8[asi_pkg::C2_TX_EN] && !tx_en) begin
      pre_pend_q <= 1'b1;
    end else if (!mod_en || !tx_en) begin
      pre_pend_q <= 1'b0;
    end else if (do_load) begin
      pre_pend_q <= 1'b0;
    end
  end

  assign baud_cfg.presc_sel = baud_q[5:4];
  assign baud_cfg.rate_sel  = baud_q[2:0];

  // Shared generator; its sample tick goes to the receiver
  asi_baud_gen u_baud (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .cfg        (baud_cfg),
    .rt_tick_q  (rx_rt_tick),
    .bit_tick_q (bit_tick)
  );

  // A new frame is chosen only on a bit tick, so every bit lasts one baud period
  assign frame_end = (state_q == asi_pkg::ST_IDLE) || (bits_left_q <= asi_pkg::LEN_MARK);
  assign do_load   = bit_tick && frame_end && mod_en && tx_en;
  assign load_char = do_load && !pre_pend_q && !ctrl2_q[asi_pkg::C2_BREAK]
                     && (state_q != asi_pkg::ST_BRK) && buf_full_q;

  // Transmit sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q     <= asi_pkg::ST_IDLE;
      shreg_q     <= asi_pkg::ALL_ONES;
      bits_left_q <= 4'h0;
    end else if (!mod_en) begin
      state_q     <= asi_pkg::ST_IDLE;
      shreg_q     <= asi_pkg::ALL_ONES;
      bits_left_q <= 4'h0;
    end else if (bit_tick) begin
      // Mid-frame: next bit, lowest first; at a boundary: next frame by priority
      if (!frame_end) begin
        shreg_q     <= {1'b1, shreg_q[10:1]};
        bits_left_q <= bits_left_q - 4'h1;
      end else if (!tx_en) begin
        state_q     <= asi_pkg::ST_IDLE;
        shreg_q     <= asi_pkg::ALL_ONES;
        bits_left_q <= 4'h0;
      end else if (pre_pend_q) begin
        state_q     <= asi_pkg::ST_PRE;
        shreg_q     <= asi_pkg::ALL_ONES;
        bits_left_q <= frame_len;
      end else if (ctrl2_q[asi_pkg::C2_BREAK]) begin
        state_q     <= asi_pkg::ST_BRK;
        shreg_q     <= asi_pkg::ALL_ZEROS;
        bits_left_q <= frame_len;
      end else if (state_q == asi_pkg::ST_BRK) begin
        // One mark bit after a break so the next start bit is seen
        state_q     <= asi_pkg::ST_PRE;
        shreg_q     <= asi_pkg::ALL_ONES;
        bits_left_q <= asi_pkg::LEN_MARK;
      end else if (buf_full_q) begin
        state_q     <= asi_pkg::ST_SEND;
        bits_left_q <= frame_len;
        if (nine) begin
          shreg_q <= {1'b1, ctrl3_q[asi_pkg::C3_TX_NINTH], buf_q, 1'b0};
        end else begin
          shreg_q <= {2'h3, buf_q, 1'b0};
        end
      end else begin
        state_q     <= asi_pkg::ST_IDLE;
        shreg_q     <= asi_pkg::ALL_ONES;
        bits_left_q <= 4'h0;
      end
    end
  end

  // Write-only holding buffer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      buf_q      <= asi_pkg::RST_REG;
      buf_full_q <= 1'b0;
    end else if (wr_data) begin
      buf_q      <= wdata8;
      buf_full_q <= 1'b1;
    end else if (load_char) begin
      buf_full_q <= 1'b0;
    end
  end

  // Empty flag: the hand-over sets it and wins over a simultaneous write
  // A data write clears it unless a hand-over comes in the same cycle; reading status first is left to software
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txe_q <= 1'b1;
    end else if (load_char) begin
      txe_q <= 1'b1;
    end else if (wr_data) begin
      txe_q <= 1'b0;
    end
  end

  // Complete only with everything drained and no preamble or break under way
  assign tc_d = (state_q == asi_pkg::ST_IDLE) && !buf_full_q && !pre_pend_q
                && !(mod_en && tx_en && ctrl2_q[asi_pkg::C2_BREAK]);

  // Registered copy; its rising edge is the complete event
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tc_q <= 1'b1;
    end else begin
      tc_q <= tc_d;
    end
  end

  // Sticky event bits, write one to clear, set wins
  genvar gi;
  generate
    for (gi = 0; gi < IRQ_W_L; gi++) begin : g_sts
      logic ev;
      logic clr;
      assign ev  = (gi == asi_pkg::IRQ_TXE) ? load_char : (tc_d && !tc_q);
      assign clr = wr_sts && wdata8[gi];
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          irq_sts_q[gi] <= 1'b0;
        end else if (ev) begin
          irq_sts_q[gi] <= 1'b1;
        end else if (clr) begin
          irq_sts_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Mask, same layout as the status bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_msk_q <= '0;
    end else if (wr_msk) begin
      irq_msk_q <= wdata8[IRQ_W_L-1:0];
    end
  end

  // One level interrupt: masked events plus the flag-and-enable requests
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (|(irq_sts_q & irq_msk_q))
               || (txe_q && ctrl2_q[asi_pkg::C2_TXE_IE])
               || (tc_q && ctrl2_q[asi_pkg::C2_TC_IE]);
    end
  end

  // Pin: NRZ level, optional inversion, released when the module is off
  assign line = (state_q == asi_pkg::ST_IDLE) ? 1'b1 : shreg_q[0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txd_q      <= 1'b1;
      txd_oe_n_q <= 1'b1;
    end else begin
      txd_q      <= line ^ ctrl1_q[asi_pkg::C1_INVERT];
      txd_oe_n_q <= !mod_en;
    end
  end

endmodule

// ---- testbench/asi_line_model.sv ----
// Far-end serial receiver: decodes frames seen on the transmit line.
// Assumes 16 cycles per bit and a line already corrected for inversion, pulled up when free.
module asi_line_model (
  input  wire logic        hclk,
  input  wire logic        line,
  input  wire logic        nine,
  output logic      [10:0] frame_q,
  output int unsigned      frames
);
  timeunit 1ns;
  timeprecision 1ps;
  int n;

  initial begin
    frame_q = 11'h000;
    frames  = 0;
    forever begin
      @(negedge line);
      repeat (8) @(posedge hclk);
      n = nine ? 11 : 10;
      // Mid-bit samples, lowest bit first
      for (int i = 0; i < n; i++) begin
        frame_q[i] = line;
        if (i < n - 1) begin
          repeat (16) @(posedge hclk);
        end
      end
      frames++;
    end
  end
endmodule

// ---- testbench/asi_tx_sva.sv ----
// Checker for the serial transmitter: pin release, line levels, bit timing, read data.
// Assumes baud select 0 and inversion changed only while the line is idle.
module asi_tx_sva (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        txd_q,
  input wire logic        txd_oe_n_q,
  input wire logic        irq_q,
  input wire logic        rx_rt_tick
);
  logic       ph_v_q;
  logic       ph_w_q;
  logic [7:0] ph_i_q;
  logic       en_q;
  logic       inv_q;
  logic       te_q;
  logic       ie_q;
  logic       brk_q;
  logic [8:0] since_q;
  logic       wr_ph;
  logic       rd_st1;

  assign wr_ph  = ph_v_q && ph_w_q;
  assign rd_st1 = ph_v_q && !ph_w_q && (ph_i_q == asi_pkg::IDX_STAT1);

  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_v_q <= 1'b0;
      ph_w_q <= 1'b0;
      ph_i_q <= 8'h00;
    end else begin
      ph_v_q <= hsel && hready && (htrans == asi_pkg::HTRANS_NONSEQ);
      ph_w_q <= hwrite;
      ph_i_q <= haddr[9:2];
    end
  end

  // Shadow of the control bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_q  <= 1'b0;
      inv_q <= 1'b0;
      te_q  <= 1'b0;
      ie_q  <= 1'b0;
      brk_q <= 1'b0;
    end else if (wr_ph && ph_i_q == asi_pkg::IDX_CTRL1) begin
      en_q  <= hwdata[asi_pkg::C1_ENABLE];
      inv_q <= hwdata[asi_pkg::C1_INVERT];
    end else if (wr_ph && ph_i_q == asi_pkg::IDX_CTRL2) begin
      te_q  <= hwdata[asi_pkg::C2_TX_EN];
      ie_q  <= hwdata[asi_pkg::C2_TXE_IE];
      brk_q <= hwdata[asi_pkg::C2_BREAK];
    end
  end

  // Cycles since the last register write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      since_q <= 9'h000;
    end else if (wr_ph) begin
      since_q <= 9'h000;
    end else if (since_q != 9'h1FF) begin
      since_q <= since_q + 9'h001;
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  pin_drive_a: assert property (en_q [*3] |-> !txd_oe_n_q)
    else $error("pin not driven while enabled");
  pin_release_a: assert property ($fell(en_q) |-> ##[1:4] txd_oe_n_q)
    else $error("pin not released");
  bit_hold_a: assert property (disable iff (!hresetn || !en_q)
    $changed(txd_q) |=> $stable(txd_q) [*8]) else $error("bit too short");
  irq_level_a: assert property (rd_st1 && hrdata[asi_pkg::S1_TXE] && ie_q |-> ##[0:2] irq_q)
    else $error("irq low with empty enabled");
  wo_data_a: assert property (ph_v_q && !ph_w_q && ph_i_q == asi_pkg::IDX_DATA
    |-> hrdata == 32'h0000_0000) else $error("data register readable");
  quiet_idle_a: assert property (en_q && !te_q && since_q > 9'h0C8 |-> txd_q == !inv_q)
    else $error("line not idle");
  break_low_a: assert property (en_q && te_q && brk_q && since_q > 9'h190
    |-> txd_q == inv_q) else $error("break not low");
  done_idle_a: assert property (rd_st1 && hrdata[asi_pkg::S1_TC] && en_q && since_q > 9'h008
    |-> txd_q == !inv_q) else $error("complete while sending");

  cover property (rd_st1 && hrdata[asi_pkg::S1_TXE] && ie_q);
  cover property ($fell(en_q));
  cover property (brk_q && since_q > 9'h190);
endmodule

bind asi_tx asi_tx_sva u_sva (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .txd_q(txd_q), .txd_oe_n_q(txd_oe_n_q),
  .irq_q(irq_q), .rx_rt_tick(rx_rt_tick)
);

// ---- testbench/asi_tx_tb.sv ----
// Testbench for the serial transmitter: AHB-Lite master tasks and one task per scenario.
// Assumes the line model on the pin and baud select 0 (16 cycles per bit).
module asi_tx_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, txd_q, txd_oe_n_q, irq_q;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        inv_tb, nine_tb, line, irq_a, rt_tb;
  logic [10:0] m_frame;
  int unsigned m_frames, fail_count, checked;
  int          cyc;

  assign line = txd_oe_n_q ? 1'b1 : (txd_q ^ inv_tb);

  asi_tx DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .txd_q(txd_q), .txd_oe_n_q(txd_oe_n_q),
    .irq_q(irq_q), .rx_rt_tick(rt_tb));
  asi_line_model PEER (.hclk(hclk), .line(line), .nine(nine_tb), .frame_q(m_frame),
    .frames(m_frames));

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: %s", $time, what);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= asi_pkg::HTRANS_NONSEQ;
    haddr  <= {22'h000000, idx, 2'h0};
    hwrite <= wr;
    hsize  <= asi_pkg::HSIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, {24'h000000, d});
  endtask

  task automatic rd(input logic [7:0] idx);
    bus(1'b0, idx, 32'h0000_0000);
  endtask

  task automatic wait_frames(input int unsigned n);
    cyc = 0;
    while (m_frames < n && cyc < 3000) begin
      @(posedge hclk);
      cyc++;
    end
    check(m_frames >= n, 1'b1, "no frame");
  endtask

  task automatic t_reset;
    rd(asi_pkg::IDX_STAT1);
    check(rv, 32'h0000_00C0, "status reset");
    rd(asi_pkg::IDX_DATA);
    check(rv, 32'h0000_0000, "data readable");
    rd(8'h30);
    check(rv, 32'h0000_0000, "unmapped read");
    check(txd_oe_n_q, 1'b1, "pin held");
    check(hresp, 1'b0, "bus response");
  endtask

  task automatic t_char;
    wr(asi_pkg::IDX_CTRL1, 8'h40);
    wr(asi_pkg::IDX_BAUD, 8'h00);
    wr(asi_pkg::IDX_CTRL2, 8'h88);
    rd(asi_pkg::IDX_STAT1);
    check(rv[asi_pkg::S1_TXE], 1'b1, "empty before write");
    wr(asi_pkg::IDX_DATA, 8'hA5);
    rd(asi_pkg::IDX_STAT1);
    check(rv, 32'h0000_0000, "status busy");
    wait_frames(1);
    check(cyc >= 300, 1'b1, "no preamble");
    check(m_frame[9:0], {1'b1, 8'hA5, 1'b0}, "frame 8");
    repeat (16) @(posedge hclk);
    rd(asi_pkg::IDX_STAT1);
    check(rv, 32'h0000_00C0, "status idle");
    check(irq_q, 1'b1, "irq empty");
    wr(asi_pkg::IDX_CTRL2, 8'h08);
    rd(asi_pkg::IDX_IRQ_STS);
    check(rv[asi_pkg::IRQ_TXE], 1'b1, "handover event");
    wr(asi_pkg::IDX_IRQ_MSK, 8'h00);
    irq_a = irq_q;
    wr(asi_pkg::IDX_IRQ_MSK, 8'h03);
    repeat (2) @(posedge hclk);
    check(irq_a ^ irq_q, 1'b1, "mask no effect");
    wr(asi_pkg::IDX_IRQ_STS, 8'h03);
    rd(asi_pkg::IDX_IRQ_STS);
    check(rv, 32'h0000_0000, "status not cleared");
    check(irq_q, 1'b0, "irq after clear");
  endtask

  task automatic t_nine;
    nine_tb = 1'b1;
    wr(asi_pkg::IDX_CTRL1, 8'h50);
    wr(asi_pkg::IDX_CTRL3, 8'h40);
    wr(asi_pkg::IDX_DATA, 8'h96);
    wait_frames(2);
    check(m_frame, {2'h3, 8'h96, 1'b0}, "frame 9");
  endtask

  task automatic t_break;
    wr(asi_pkg::IDX_CTRL2, 8'h00);
    wr(asi_pkg::IDX_CTRL3, 8'h00);
    nine_tb = 1'b0;
    inv_tb  = 1'b1;
    wr(asi_pkg::IDX_CTRL1, 8'h60);
    repeat (250) @(posedge hclk);
    check(txd_q, 1'b0, "idle not inverted");
    wr(asi_pkg::IDX_CTRL2, 8'h09);
    repeat (500) @(posedge hclk);
    check(txd_q, 1'b1, "break level");
    wr(asi_pkg::IDX_CTRL2, 8'h08);
    rv = 32'h0;
    for (int i = 0; i < 200 && rv[asi_pkg::S1_TC] !== 1'b1; i++) begin
      rd(asi_pkg::IDX_STAT1);
    end
    check(rv[asi_pkg::S1_TC], 1'b1, "no complete");
    check(txd_q, 1'b0, "idle after break");
  endtask

  task automatic t_release;
    int n;
    inv_tb = 1'b0;
    wr(asi_pkg::IDX_CTRL1, 8'h40);
    wr(asi_pkg::IDX_CTRL2, 8'h00);
    wr(asi_pkg::IDX_CTRL2, 8'h08);
    wr(asi_pkg::IDX_DATA, 8'h5A);
    repeat (250) @(posedge hclk);
    wr(asi_pkg::IDX_CTRL1, 8'h00);
    repeat (4) @(posedge hclk);
    check(txd_oe_n_q, 1'b1, "pin kept mid frame");
    wr(asi_pkg::IDX_BAUD, 8'h11);
    repeat (2) @(posedge hclk);
    n = 0;
    repeat (60) begin
      @(posedge hclk);
      if (rt_tb === 1'b1) begin
        n++;
      end
    end
    check(n, 10, "sample tick rate");
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 32'h0;
    inv_tb = 1'b0;
    nine_tb = 1'b0;
    fail_count = 0;
    checked = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_char;
    t_nine;
    t_break;
    t_release;
    complete_run;
  end

  initial begin
    repeat (20000) @(posedge hclk);
    fail_count++;
    complete_run;
  end
endmodule
